//--- hw/oosts_top.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
module oosts_top
    import oosts_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = OOSTS_TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire oosts_zone_t zone_raw,
    input  wire oosts_zone_t rgt_blinder,
    input  wire oosts_zone_t lft_blinder,
    input  wire logic [15:0] pos_seq_current,
    input  wire logic        fault_detect_in,
    input  wire logic        trip_block_input,
    output oosts_zone_t      zone_out,
    output logic             timer_two_pickup,
    output logic             timer_three_pickup,
    output logic             timer_four_pickup,
    output logic             swing_block_out,
    output logic             swing_block_releasable_out,
    output logic             disturbance_detect_out,
    output logic             trip_out,
    output logic             incoming_out,
    output logic             outgoing_out
);

    logic [3:0]    ctrl;
    logic [15:0]   set_reg [1:7];
    logic          dp_wr;
    logic [3:0]    dp_idx;
    logic          ap_take;
    logic          ap_map;
    logic [3:0]    ap_idx;
    logic [31:0]   rd_word;
    logic [15:0]   div_cnt;
    logic          tick;
    logic          en;
    logic          three;
    logic          delayed;
    logic          supv_ok;
    logic [2:0]    blind_ok;
    oosts_zone_t   next_zq;
    oosts_zone_t   zq;
    oosts_state_t  state;
    oosts_state_t  next_state;
    logic [3:0]    cond;
    logic [3:0]    expd;
    logic [15:0]   tcnt [0:3];
    logic [15:0]   dly  [0:3];
    logic          blk;
    logic          next_blk;
    logic [15:0]   rd_cnt;
    logic          rd_done;
    logic          kill;
    logic          next_kill;
    logic          enter_arm;
    logic          trip_ev;
    logic [15:0]   seal_cnt;
    logic          trip_act;
    oosts_status_t next_st;
    oosts_status_t st_q;

    // The slave always answers at once with an OKAY response.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address phase decode; only the low 36 bytes are mapped.
    assign ap_take = hsel & htrans[OOSTS_HTRANS_ACTIVE] & hready;
    assign ap_idx  = haddr[5:2];
    assign ap_map  = (haddr[31:6] == 26'h0) && (ap_idx <= OOSTS_IDX_STAT);

    // Read selection; unmapped words and unused upper bits read as zero.
    assign rd_word = !ap_map ? 32'h0 :
                     (ap_idx == OOSTS_IDX_CTRL) ? {28'h0, ctrl} :
                     (ap_idx == OOSTS_IDX_STAT) ? {15'h0, st_q} :
                     {16'h0, set_reg[ap_idx]};

    // Capture the address phase; read data is loaded for the data phase.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dp_wr  <= 1'b0;
            dp_idx <= 4'h0;
            hrdata <= 32'h0;
        end
        else
        begin
            dp_wr  <= ap_take & hwrite & ap_map;
            dp_idx <= ap_idx;
            if (ap_take & !hwrite)
            begin
                hrdata <= rd_word;
            end
        end
    end

    // Control register write in the data phase.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl <= OOSTS_CTRL_RST;
        end
        else if (dp_wr && dp_idx == OOSTS_IDX_CTRL)
        begin
            ctrl <= hwdata[3:0];
        end
    end

    // Supervision level and timer settings, one 16-bit word each.
    for (genvar gr = 1; gr <= 7; gr++)
    begin : g_set
        always_ff @(posedge clk or negedge resetn)
        begin
            if (!resetn)
            begin
                set_reg[gr] <= OOSTS_SET_RST[gr];
            end
            else if (dp_wr && dp_idx == 4'(gr))
            begin
                set_reg[gr] <= hwdata[15:0];
            end
        end
    end

    // Millisecond tick divider.
    assign tick = (div_cnt == 16'(TICK_CYCLES - 1));

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            div_cnt <= 16'h0;
        end
        else
        begin
            div_cnt <= tick ? 16'h0 : div_cnt + 16'h1;
        end
    end

    // Mode settings.
    assign en      = ctrl[OOSTS_CTRL_EN];
    assign three   = ctrl[OOSTS_CTRL_3STEP];
    assign delayed = ctrl[OOSTS_CTRL_DELAYED];

    // Zone qualification by supervision, blinders, mode and enable.
    assign supv_ok  = (pos_seq_current >= set_reg[OOSTS_IDX_SUPV]);
    assign blind_ok = ctrl[OOSTS_CTRL_MHO] ? (rgt_blinder & lft_blinder)
                                           : 3'h7;
    assign next_zq  = {3{en & supv_ok}} & zone_raw & blind_ok
                      & {1'b1, three, 1'b1};

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            zq <= '0;
        end
        else
        begin
            zq <= next_zq;
        end
    end

    // Timer conditions; each depends on the stage reached so far.
    assign cond[0] = (state == S_IDLE) & zq.outer
                     & (three ? !zq.middle : !zq.inner);
    assign cond[1] = (state == S_ONE) & three & zq.middle & !zq.inner;
    assign cond[2] = (three ? (state == S_TWO) : (state == S_ONE))
                     & zq.inner;
    assign cond[3] = (state == S_ARM) & delayed & zq.outer & !zq.inner;

    // Pickup delays of the four timers.
    assign dly[0] = set_reg[OOSTS_IDX_PD1];
    assign dly[1] = set_reg[OOSTS_IDX_PD2];
    assign dly[2] = set_reg[OOSTS_IDX_PD3];
    assign dly[3] = set_reg[OOSTS_IDX_PD4];

    // Pickup timers count ticks while the condition holds, else clear.
    for (genvar gt = 0; gt < 4; gt++)
    begin : g_tmr
        always_ff @(posedge clk or negedge resetn)
        begin
            if (!resetn)
            begin
                tcnt[gt] <= 16'h0;
            end
            else if (!cond[gt])
            begin
                tcnt[gt] <= 16'h0;
            end
            else if (tick && tcnt[gt] != 16'hffff)
            begin
                tcnt[gt] <= tcnt[gt] + 16'h1;
            end
        end
        assign expd[gt] = cond[gt] && (tcnt[gt] >= dly[gt]);
    end

    // Out-of-step sequence; every stage falls back when outer is left.
    always_comb
    begin
        next_state = state;
        unique case (state)
            S_IDLE:
                if (expd[0]) next_state = S_ONE;
            S_ONE:
                if (three && expd[1]) next_state = S_TWO;
                else if (!three && expd[2]) next_state = S_ARM;
            S_TWO:
                if (expd[2]) next_state = S_ARM;
            S_ARM:
                if (delayed && expd[3]) next_state = S_LATE;
            S_LATE:
                next_state = S_LATE;
            default:
                next_state = S_IDLE;
        endcase
        if (!zq.outer || !en)
        begin
            next_state = S_IDLE;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= S_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Swing block sets after delay 1, drops after reset delay outside.
    assign rd_done  = blk & !zq.outer & (rd_cnt >= set_reg[OOSTS_IDX_RD1]);
    assign next_blk = en & (expd[0] | (blk & !rd_done));
    // A fault once blocking is up releases the unblock output.
    assign next_kill = next_blk & blk & (kill | fault_detect_in);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            blk    <= 1'b0;
            kill   <= 1'b0;
            rd_cnt <= 16'h0;
        end
        else
        begin
            blk  <= next_blk;
            kill <= next_kill;
            if (!blk || zq.outer)
            begin
                rd_cnt <= 16'h0;
            end
            else if (tick && rd_cnt != 16'hffff)
            begin
                rd_cnt <= rd_cnt + 16'h1;
            end
        end
    end

    // Trip events: on arming in early mode, on leaving outer when late.
    assign enter_arm = (state != S_ARM) & (next_state == S_ARM);
    assign trip_ev   = delayed ? ((state == S_LATE) & !zq.outer)
                               : enter_arm;
    assign trip_act  = trip_ev | (seal_cnt != 16'h0);

    // Seal-in counter keeps the trip up for the hold time in ms.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            seal_cnt <= 16'h0;
        end
        else if (!en)
        begin
            seal_cnt <= 16'h0;
        end
        else if (trip_ev)
        begin
            seal_cnt <= set_reg[OOSTS_IDX_SEAL];
        end
        else if (tick && seal_cnt != 16'h0)
        begin
            seal_cnt <= seal_cnt - 16'h1;
        end
    end

    // Gather all outputs; the trip block only gates the trip itself.
    always_comb
    begin
        next_st          = '0;
        next_st.state    = state;
        next_st.zone     = zq;
        next_st.tmr2     = cond[1];
        next_st.tmr3     = cond[2];
        next_st.tmr4     = cond[3];
        next_st.blk      = blk;
        next_st.unblk    = blk & !kill;
        next_st.dd       = en & fault_detect_in;
        next_st.trip     = en & trip_act & !trip_block_input;
        next_st.incoming = en & enter_arm;
        next_st.outgoing = en & !zq.outer
                           & ((state == S_ARM) | (state == S_LATE));
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= next_st;
        end
    end

    // Output pins come straight from the status flops.
    assign zone_out                   = st_q.zone;
    assign timer_two_pickup           = st_q.tmr2;
    assign timer_three_pickup         = st_q.tmr3;
    assign timer_four_pickup          = st_q.tmr4;
    assign swing_block_out            = st_q.blk;
    assign swing_block_releasable_out = st_q.unblk;
    assign disturbance_detect_out     = st_q.dd;
    assign trip_out                   = st_q.trip;
    assign incoming_out               = st_q.incoming;
    assign outgoing_out               = st_q.outgoing;

endmodule : oosts_top

//--- hw/oosts_pkg.sv
package oosts_pkg;

    // Clock rate and the millisecond tick derived from it.
    localparam int unsigned OOSTS_CLK_PERIOD_NS = 20;
    localparam int unsigned OOSTS_TICK_TIME_US  = 1000;
    localparam int unsigned OOSTS_TICK_CYCLES   =
        OOSTS_TICK_TIME_US * 1000 / OOSTS_CLK_PERIOD_NS;

    // Word indices of the registers; byte address is four times the index.
    localparam logic [3:0] OOSTS_IDX_CTRL = 4'h0;
    localparam logic [3:0] OOSTS_IDX_SUPV = 4'h1;
    localparam logic [3:0] OOSTS_IDX_PD1  = 4'h2;
    localparam logic [3:0] OOSTS_IDX_RD1  = 4'h3;
    localparam logic [3:0] OOSTS_IDX_PD2  = 4'h4;
    localparam logic [3:0] OOSTS_IDX_PD3  = 4'h5;
    localparam logic [3:0] OOSTS_IDX_PD4  = 4'h6;
    localparam logic [3:0] OOSTS_IDX_SEAL = 4'h7;
    localparam logic [3:0] OOSTS_IDX_STAT = 4'h8;

    // Control register bit positions and reset value.
    localparam int unsigned OOSTS_CTRL_EN      = 0;
    localparam int unsigned OOSTS_CTRL_3STEP   = 1;
    localparam int unsigned OOSTS_CTRL_DELAYED = 2;
    localparam int unsigned OOSTS_CTRL_MHO     = 3;
    localparam logic [3:0]  OOSTS_CTRL_RST     = 4'hc;

    // Reset values of supervision level (milli-pu) and timers (ms).
    localparam logic [15:0] OOSTS_SET_RST [1:7] = '{
        16'h0258, 16'h001e, 16'h0032, 16'h0011, 16'h0009, 16'h0011, 16'h0190};

    // AHB transfer type bit that marks an active transfer.
    localparam int unsigned OOSTS_HTRANS_ACTIVE = 1;

    typedef struct packed {
        logic outer;
        logic middle;
        logic inner;
    } oosts_zone_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_ONE  = 5'h02,
        S_TWO  = 5'h04,
        S_ARM  = 5'h08,
        S_LATE = 5'h10
    } oosts_state_t;

    typedef struct packed {
        logic [4:0]  state;
        oosts_zone_t zone;
        logic        tmr2;
        logic        tmr3;
        logic        tmr4;
        logic        blk;
        logic        unblk;
        logic        dd;
        logic        trip;
        logic        incoming;
        logic        outgoing;
    } oosts_status_t;

endpackage : oosts_pkg

//--- tb/oosts_zone_model.sv
module oosts_zone_model
    import oosts_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [1:0]  locus,
    input  wire logic        bld_ok,
    input  wire logic        cur_hi,
    output oosts_zone_t      zone_raw,
    output oosts_zone_t      rgt_blinder,
    output oosts_zone_t      lft_blinder,
    output logic [15:0]      pos_seq_current
);
    // Depth of the locus gives nested flags that follow locus directly; clk is not used.
    assign zone_raw.outer  = (locus >= 2'h1);
    assign zone_raw.middle = (locus >= 2'h2);
    assign zone_raw.inner  = (locus == 2'h3);
    // Blinders either pass all zones or none, so the mho gating is visible.
    assign rgt_blinder = {3{bld_ok}};
    assign lft_blinder = {3{bld_ok}};
    // Current sits well above or well below the reset supervision level.
    assign pos_seq_current = cur_hi ? 16'h03e8 : 16'h0064;
endmodule : oosts_zone_model

//--- tb/oosts_checker.sv
module oosts_checker
    import oosts_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = OOSTS_TICK_CYCLES
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire oosts_zone_t zone_out,
    input wire logic        fault_detect_in,
    input wire logic        trip_block_input,
    input wire logic        timer_two_pickup,
    input wire logic        timer_three_pickup,
    input wire logic        timer_four_pickup,
    input wire logic        swing_block_out,
    input wire logic        swing_block_releasable_out,
    input wire logic        disturbance_detect_out,
    input wire logic        trip_out,
    input wire logic        incoming_out,
    input wire logic        outgoing_out
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Output relations to their causes at the inputs and to the zone flags.
    a_trip_gated: assert property ($past(trip_block_input) |-> !trip_out)
        else $error("trip raised while trip block active");
    a_dd_follow: assert property (!fault_detect_in |=> !disturbance_detect_out)
        else $error("disturbance output without fault");
    a_inc_pulse: assert property (incoming_out |=> !incoming_out [*2])
        else $error("incoming flag longer than one cycle");
    a_out_exit: assert property (outgoing_out |-> !zone_out.outer ##1 !outgoing_out)
        else $error("outgoing flag while inside outer zone");
    a_unblk_sub: assert property (swing_block_releasable_out |-> swing_block_out)
        else $error("releasable block without block");
    a_block_drop: assert property ($fell(swing_block_out) |-> !zone_out.outer)
        else $error("block dropped inside outer zone");
    a_tmr2_zone: assert property (timer_two_pickup |-> zone_out.middle && !zone_out.inner)
        else $error("timer two pickup outside its band");
    a_tmr3_zone: assert property (timer_three_pickup |-> zone_out.inner)
        else $error("timer three pickup outside inner zone");
    a_tmr4_zone: assert property (timer_four_pickup |-> zone_out.outer && !zone_out.inner)
        else $error("timer four pickup outside its band");

    // Main scenarios seen at least once.
    c_trip: cover property ($rose(trip_out));
    c_release: cover property (swing_block_out && !swing_block_releasable_out);
    c_outgoing: cover property (outgoing_out);
endmodule : oosts_checker

bind oosts_top oosts_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
    .clk, .resetn, .zone_out, .fault_detect_in, .trip_block_input,
    .timer_two_pickup, .timer_three_pickup, .timer_four_pickup, .swing_block_out,
    .swing_block_releasable_out, .disturbance_detect_out, .trip_out,
    .incoming_out, .outgoing_out);

//--- tb/testbench.sv
module testbench
    import oosts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [3:0] ctrl;
        logic [2:0] cond;
        logic [3:0] exp;
    } oosts_row_t;

    localparam int TICK = 10;
    // Control word, {trip block, high current, blinders}, {trip, in, out, block}.
    localparam oosts_row_t ROWS [8] = '{
        '{4'hb, 3'h3, 4'hf}, '{4'hf, 3'h3, 4'hf}, '{4'h5, 3'h3, 4'hf},
        '{4'h1, 3'h3, 4'hf}, '{4'hf, 3'h7, 4'h7}, '{4'h7, 3'h1, 4'h0},
        '{4'hf, 3'h2, 4'h0}, '{4'he, 3'h3, 4'h0}};
    localparam logic [31:0] RST_VAL [10] = '{32'hc, 32'h258, 32'h1e, 32'h32,
        32'h11, 32'h9, 32'h11, 32'h190, 32'h1000, 32'h0};
    localparam logic [15:0] SETV [2:7] = '{16'h2, 16'h3, 16'h2, 16'h2, 16'h2, 16'h4};

    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic [31:0] hrdata;
    logic [1:0]  locus = 2'h0;
    logic        bld_ok = 1'b1;
    logic        cur_hi = 1'b1;
    logic        fault_detect_in = 1'b0;
    logic        trip_block_input = 1'b0;
    oosts_zone_t zone_raw, rgt_blinder, lft_blinder;
    logic [15:0] pos_seq_current;
    logic        swing_block_out, swing_block_releasable_out, disturbance_detect_out;
    logic        trip_out, incoming_out, outgoing_out;
    logic [3:0]  saw;
    logic        saw_dd;
    logic [31:0] q;
    logic [5:0]  saw_aux;
    logic        hresp;
    oosts_zone_t zone_out;
    logic        timer_two_pickup, timer_three_pickup, timer_four_pickup;
    int          err_total = 0;
    int          cmp_count = 0;

    always #10 clk = ~clk;

    oosts_zone_model partner (.clk, .locus, .bld_ok, .cur_hi, .zone_raw, .rgt_blinder,
        .lft_blinder, .pos_seq_current);

    oosts_top #(.TICK_CYCLES(TICK)) uut (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hreadyout(hready), .hrdata, .hresp, .zone_raw,
        .rgt_blinder, .lft_blinder, .pos_seq_current, .fault_detect_in, .trip_block_input,
        .zone_out, .timer_two_pickup, .timer_three_pickup, .timer_four_pickup,
        .swing_block_out, .swing_block_releasable_out, .disturbance_detect_out,
        .trip_out, .incoming_out, .outgoing_out);

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // Bounded wait for the slave's ready; running out ends the run.
    task automatic wait_rdy();
        int n;
        n = 0;
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                err_total++;
                complete_run();
            end
            @(posedge clk);
        end
    endtask : wait_rdy

    // One single word transfer; read data lands in q at the data phase edge.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        wait_rdy();
        q = hrdata;
    endtask : bus

    // Hold the locus for some milliseconds, sampling outputs between edges.
    task automatic hold(input logic [1:0] l, input int ms);
        @(posedge clk);
        locus <= l;
        repeat (ms * TICK)
        begin
            @(negedge clk);
            saw    = saw | {trip_out, incoming_out, outgoing_out, swing_block_out};
            saw_dd = saw_dd | disturbance_detect_out;
            saw_aux = saw_aux | {zone_out, timer_two_pickup, timer_three_pickup,
                timer_four_pickup};
        end
    endtask : hold

    // A full swing through all zones with a fault pulse before the inner stage.
    task automatic swing(input oosts_row_t r);
        logic [5:0] aux_exp;
        // Zones and timer pickups that a full swing must show: middle and
        // timer two only in three-step, timer four only in delayed mode.
        aux_exp = {6{r.exp[0]}} & {1'b1, r.ctrl[1], 1'b1, r.ctrl[1], 1'b1, r.ctrl[2]};
        bus(1'b1, 32'h0, {28'h0, r.ctrl});
        @(posedge clk);
        trip_block_input <= r.cond[2];
        cur_hi           <= r.cond[1];
        bld_ok           <= r.cond[0];
        saw    = 4'h0;
        saw_dd = 1'b0;
        saw_aux = 6'h0;
        hold(2'h1, 5);
        hold(2'h2, 5);
        cmp({30'h0, swing_block_out, swing_block_releasable_out}, {30'h0, {2{r.exp[0]}}});
        @(posedge clk);
        fault_detect_in <= 1'b1;
        @(posedge clk);
        fault_detect_in <= 1'b0;
        // The disturbance output stands for this one cycle only.
        @(negedge clk);
        saw_dd = saw_dd | disturbance_detect_out;
        hold(2'h3, 5);
        cmp({30'h0, swing_block_out, swing_block_releasable_out}, {30'h0, r.exp[0], 1'b0});
        hold(2'h1, 5);
        hold(2'h0, 10);
        cmp({28'h0, saw}, {28'h0, r.exp});
        cmp({31'h0, saw_dd}, {31'h0, r.ctrl[0]});
        cmp({26'h0, saw_aux}, {26'h0, aux_exp});
        cmp({30'h0, swing_block_out, trip_out}, 32'h0);
    endtask : swing

    // Settings, swing table, then a second reset and register checks.
    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 2; i < 8; i++)
            bus(1'b1, 32'(i * 4), {16'h0, SETV[i]});
        for (int i = 0; i < 8; i++)
        begin
            swing(ROWS[i]);
            $display("swing test %0d done", i);
        end
        @(posedge clk);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            bus(1'b0, 32'(i * 4), 32'h0);
            cmp(q, RST_VAL[i]);
        end
        bus(1'b1, 32'h20, 32'hffff);
        bus(1'b1, 32'h24, 32'hffff);
        bus(1'b0, 32'h20, 32'h0);
        cmp(q, RST_VAL[8]);
        bus(1'b0, 32'h24, 32'h0);
        cmp(q, RST_VAL[9]);
        cmp({31'h0, hresp}, 32'h0);
        $display("register test done");
        complete_run();
    end
endmodule : testbench
